// File: pwt_top.sv
// Contract
// - Pin inverts at every underflow, alternating reloads
// - First interval after start is primary
// - Count clock: div one, two, eight, companion
// - Down counter reloads alternately, never stops
// - Intervals last (n+1)(m+1) and (n+1)(p+1)
// - Run flag starts and stops counting
// - Interrupt at secondary underflow, with pin change
// - Pin is pulse output in this mode
// - Primary and prescaler reads return counts
// - Running writes touch reload registers only
// - Level select sets primary/secondary pin levels
// - Switch bit: toggle, or drive port latch
// - Stopped writes load reload and counter
// - Mode field 01 selects waveform mode
// - Primary write commits both, next primary
// - Switch bit sampled at start or interrupt
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module pwt_top
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire pwt_pkg::pwt_apb_req_s apb_i,
    output pwt_pkg::pwt_apb_rsp_s apb_o,
    input wire logic companion_uflow_i,
    output logic waveform_out_pin_o,
    output logic irq_o
);
    import pwt_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mode_reg;       // timer_mode_register
        logic [7:0] woc_reg;        // waveform_output_control
        logic [7:0] presc_rl;       // prescaler_reload
        logic [7:0] sec_rl;         // secondary_reload (written value)
        logic [7:0] pri_rl;         // primary_reload (written value)
        logic [7:0] ocr_reg;        // output_control_register
        logic [7:0] ctl_reg;        // Clock select and port latch
        logic [1:0] status;         // Sticky events
        logic [1:0] mask;           // Interrupt enables
        logic [7:0] presc_cnt;      // Prescaler count
        logic [7:0] main_cnt;       // Main count
        logic [7:0] pri_act;        // Primary value in use
        logic [7:0] sec_act;        // Secondary value in use
        logic pend;                 // New values await next primary
        pwt_phase_e phase;          // Interval being counted
        logic osw_act;              // Sampled output switch
        logic [2:0] div;            // Free running divider
        logic run_q;                // Run flag one cycle ago
        logic pin;                  // Waveform pin
        logic irq;                  // Interrupt line
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pwt_state_s;

    pwt_state_s st;                 // Registered state
    pwt_state_s next_st;            // Next state

    logic pwm_mode;                 // Waveform generation selected
    logic run;                      // Counting enabled
    logic run_rise;                 // Counting begins this cycle
    logic tick;                     // Count clock enable
    logic uflow;                    // Main counter underflow
    logic samp_osw;                 // Switch bit sampled this cycle
    logic acc;                      // Bus transfer completes
    logic wr;                       // Write completes
    logic rd;                       // Read completes
    logic [7:0] wdat;               // Write data, low byte

    // Register read mux, shared by the bus read and nothing else
    function automatic logic [7:0] rd_mux(input pwt_state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_MODE: v = s.mode_reg;
            ADDR_WOC: v = s.woc_reg;
            ADDR_PRESC: v = s.presc_cnt;    // Count, not reload
            ADDR_SEC: v = s.sec_rl;
            ADDR_PRI: v = s.main_cnt;       // Count, not reload
            ADDR_OCR: v = s.ocr_reg;
            ADDR_CTL: v = s.ctl_reg;
            ADDR_STAT: v = {6'h00, s.status};
            ADDR_MASK: v = {6'h00, s.mask};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Address decode
    function automatic logic mapped(input logic [7:0] a);
        return (a >= ADDR_MODE) && (a <= ADDR_MASK) && (a[1:0] == 2'h0);
    endfunction

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    always_comb
    begin
        pwm_mode = ({st.mode_reg[MODE_HIGH_BIT], st.mode_reg[MODE_LOW_BIT]} == MODE_PWG);
        run = st.mode_reg[RUN_BIT];
        run_rise = run && !st.run_q;
        acc = apb_i.psel && apb_i.penable && st.pready;
        wr = acc && apb_i.pwrite && mapped(apb_i.paddr);
        rd = acc && !apb_i.pwrite;
        wdat = apb_i.pwdata[7:0];
        // Count clock choice; dividers are enables, not clocks
        unique case (st.ctl_reg[1:0])
            SEL_DIV_ONE: tick = 1'b1;
            SEL_DIV_TWO: tick = st.div[0];
            SEL_DIV_EIGHT: tick = (st.div == DIV_LAST);
            SEL_COMPANION: tick = companion_uflow_i;
        endcase
        // Underflow needs prescaler and main both at zero
        uflow = run && !run_rise && tick && (st.presc_cnt == 8'h00) && (st.main_cnt == 8'h00);
        samp_osw = run_rise || (uflow && st.phase == PH_SECONDARY);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.div = st.div + 3'h1;
        next_st.run_q = run;

        // Bus handshake: one wait state, then answer
        next_st.pready = apb_i.psel && apb_i.penable && !st.pready;
        if (next_st.pready)
        begin
            next_st.pslverr = !mapped(apb_i.paddr);
            next_st.prdata = apb_i.pwrite ? 32'h0000_0000 : {24'h000000, rd_mux(st, apb_i.paddr)};
        end

        // Read of status clears it; hardware sets below win
        if (rd && apb_i.paddr == ADDR_STAT)
        begin
            next_st.status = 2'h0;
        end

        // Register writes
        if (wr)
        begin
            unique case (apb_i.paddr)
                ADDR_MODE: next_st.mode_reg = wdat;
                ADDR_WOC: next_st.woc_reg = wdat;
                ADDR_OCR: next_st.ocr_reg = wdat;
                ADDR_CTL: next_st.ctl_reg = wdat;
                ADDR_MASK: next_st.mask = wdat[1:0];
                ADDR_STAT: next_st.status = st.status;         // Read only
                ADDR_PRESC:
                begin
                    next_st.presc_rl = wdat;
                    // Counter too only when stopped or plain timer
                    if (!run || (!pwm_mode && !st.mode_reg[WTS_BIT]))
                    begin
                        next_st.presc_cnt = wdat;
                    end
                end
                ADDR_SEC:
                begin
                    next_st.sec_rl = wdat;                     // Reload; value in use too when stopped
                    if (!run)
                    begin
                        next_st.sec_act = wdat;
                    end
                end
                ADDR_PRI:
                begin
                    next_st.pri_rl = wdat;
                    if (!run || (!pwm_mode && !st.mode_reg[WTS_BIT]))
                    begin
                        // Loaded at once when stopped
                        next_st.pri_act = wdat;
                        next_st.sec_act = st.sec_rl;
                        next_st.main_cnt = wdat;
                        next_st.pend = 1'b0;
                    end
                    else
                    begin
                        // Commit waits for next primary interval
                        next_st.pend = 1'b1;
                    end
                end
                default: next_st.mode_reg = st.mode_reg;
            endcase
        end

        // Start: always begin with the primary interval
        if (run_rise)
        begin
            next_st.phase = PH_PRIMARY;
            next_st.main_cnt = st.pri_act;
            next_st.presc_cnt = st.presc_rl;
        end
        else if (run && tick)
        begin
            if (st.presc_cnt != 8'h00)
            begin
                next_st.presc_cnt = st.presc_cnt - 8'h01;
            end
            else
            begin
                next_st.presc_cnt = st.presc_rl;
                if (st.main_cnt != 8'h00)
                begin
                    next_st.main_cnt = st.main_cnt - 8'h01;   // Decrement
                end
                else if (st.phase == PH_SECONDARY)
                begin
                    // End of full cycle: back to primary
                    next_st.phase = PH_PRIMARY;
                    next_st.status[ST_CYCLE] = 1'b1;
                    if (st.pend)
                    begin
                        next_st.pri_act = st.pri_rl;
                        next_st.sec_act = st.sec_rl;
                        next_st.pend = 1'b0;
                        next_st.main_cnt = st.pri_rl;
                    end
                    else
                    begin
                        next_st.main_cnt = st.pri_act;
                    end
                end
                else
                begin
                    next_st.phase = PH_SECONDARY;
                    next_st.main_cnt = st.sec_act;
                    next_st.status[ST_PRIMARY] = 1'b1;
                end
            end
        end

        // Switch bit only taken at start or interrupt
        if (samp_osw)
        begin
            next_st.osw_act = st.ocr_reg[OSW_BIT];
        end

        // Pin: pulse output in waveform mode while running with switch off, port latch otherwise
        if (pwm_mode && run && !next_st.osw_act)
        begin
            // Level select picks the polarity of both intervals
            next_st.pin = next_st.woc_reg[OPL_BIT] ^ (next_st.phase == PH_SECONDARY);
        end
        else
        begin
            next_st.pin = next_st.ctl_reg[LATCH_BIT];
        end

        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.phase <= PH_PRIMARY;
            st.presc_rl <= RST_COUNT;
            st.presc_cnt <= RST_COUNT;
            st.pri_rl <= RST_COUNT;
            st.sec_rl <= RST_COUNT;
            st.pri_act <= RST_COUNT;
            st.sec_act <= RST_COUNT;
            st.main_cnt <= RST_COUNT;
            st.mode_reg <= RST_REG;
            st.woc_reg <= RST_REG;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign apb_o.pready = st.pready;
    assign apb_o.pslverr = st.pslverr;
    assign apb_o.prdata = st.prdata;
    assign waveform_out_pin_o = st.pin;
    assign irq_o = st.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic osw_hold;                 // Switch stays off across underflow
    assign osw_hold = !st.osw_act && !st.ocr_reg[OSW_BIT] && pwm_mode && !wr;

    property p_toggle;
        uflow && osw_hold |=> st.pin != $past(st.pin);
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin did not invert at underflow");

    property p_first_primary;
        run_rise |=> st.phase == PH_PRIMARY && st.main_cnt == $past(st.pri_act);
    endproperty
    a_first_primary: assert property (p_first_primary) else $error("start not on primary");

    property p_alternate;
        uflow |=> st.phase != $past(st.phase);
    endproperty
    a_alternate: assert property (p_alternate) else $error("phase did not alternate");

    property p_sec_load;
        uflow && st.phase == PH_PRIMARY |=> st.main_cnt == $past(st.sec_act);
    endproperty
    a_sec_load: assert property (p_sec_load) else $error("secondary value not loaded");

    property p_stopped;
        !run && !wr ##1 !run && !wr |-> $stable(st.main_cnt) && $stable(st.phase);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_irq_cycle;
        uflow && st.phase == PH_SECONDARY |=> st.status[ST_CYCLE] && st.phase == PH_PRIMARY;
    endproperty
    a_irq_cycle: assert property (p_irq_cycle) else $error("no interrupt at cycle end");

    property p_read_count;
        rd && apb_i.paddr == ADDR_PRI |-> st.prdata[7:0] == $past(st.main_cnt);
    endproperty
    a_read_count: assert property (p_read_count) else $error("primary read not the count");

    property p_run_write;
        wr && apb_i.paddr == ADDR_PRI && run && pwm_mode && !tick && !run_rise
            |=> st.main_cnt == $past(st.main_cnt) && st.pend;
    endproperty
    a_run_write: assert property (p_run_write) else $error("running write hit counter");

    property p_level;
        pwm_mode && run && !st.osw_act && st.run_q |-> st.pin == (st.woc_reg[OPL_BIT] ^ (st.phase == PH_SECONDARY));
    endproperty
    a_level: assert property (p_level) else $error("pin level wrong for interval");

    property p_stop_load;
        wr && apb_i.paddr == ADDR_PRI && !run |=> st.main_cnt == $past(wdat) && st.pri_act == $past(wdat);
    endproperty
    a_stop_load: assert property (p_stop_load) else $error("stopped write did not load");

    property p_osw_sample;
        !samp_osw |=> $stable(st.osw_act);
    endproperty
    a_osw_sample: assert property (p_osw_sample) else $error("switch bit taken off-time");

    property p_presc;
        run && !run_rise && tick && st.presc_cnt != 8'h00 && !wr
            |=> st.presc_cnt == $past(st.presc_cnt) - 8'h01 && $stable(st.main_cnt);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler step wrong");

endmodule

`default_nettype wire

// File: pwt_pkg.sv
package pwt_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h80;    // timer_mode_register
    localparam logic [7:0] ADDR_WOC = 8'h84;     // waveform_output_control
    localparam logic [7:0] ADDR_PRESC = 8'h88;   // prescaler_reload / count
    localparam logic [7:0] ADDR_SEC = 8'h8C;     // secondary_reload
    localparam logic [7:0] ADDR_PRI = 8'h90;     // primary_reload / count
    localparam logic [7:0] ADDR_OCR = 8'h94;     // output_control_register
    localparam logic [7:0] ADDR_CTL = 8'h98;     // Clock select, port latch
    localparam logic [7:0] ADDR_STAT = 8'h9C;    // Interrupt status, read clears
    localparam logic [7:0] ADDR_MASK = 8'hA0;    // Interrupt mask

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MODE_LOW_BIT = 4;     // mode_select_low
    localparam int MODE_HIGH_BIT = 5;    // mode_select_high
    localparam int WTS_BIT = 6;          // write_target_select
    localparam int RUN_BIT = 7;          // count_run_flag
    localparam int OPL_BIT = 5;          // output_level_select
    localparam int OSW_BIT = 0;          // output_switch_select
    localparam int LATCH_BIT = 2;        // port_latch_bit in control reg
    localparam int ST_CYCLE = 0;         // Full waveform cycle done
    localparam int ST_PRIMARY = 1;       // Primary interval done

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'hFF;
    localparam logic [1:0] MODE_PWG = 2'h1;       // Waveform generation mode
    localparam logic [1:0] SEL_DIV_ONE = 2'h0;    // clock_div_one
    localparam logic [1:0] SEL_DIV_TWO = 2'h1;    // clock_div_two
    localparam logic [1:0] SEL_DIV_EIGHT = 2'h2;  // clock_div_eight
    localparam logic [1:0] SEL_COMPANION = 2'h3;  // Companion underflow
    localparam logic [2:0] DIV_LAST = 3'h7;       // Last step of divide by eight

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_PRIMARY = 2'b01,
        PH_SECONDARY = 2'b10
    } pwt_phase_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pwt_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pwt_apb_rsp_s;

endpackage

// File: programmable_waveform_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none

module programmable_waveform_timer_bench;
    import pwt_pkg::*;

    // ------------------------------------------------------------
    // Clock, reset and design hookup
    // ------------------------------------------------------------
    logic sys_clk = 1'b0; // 125 MHz system clock
    logic rst = 1'b1; // Synchronous reset, active high
    pwt_apb_req_s req = '0; // Bus request driven by the bench
    pwt_apb_rsp_s rsp; // Bus answer from the design
    logic comp_pulse = 1'b0; // Companion underflow stand-in
    logic [1:0] comp_div = 2'h0; // Spaces companion pulses three cycles apart
    logic pin; // Waveform pin
    logic irq; // Level interrupt
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0; // Cycle count, also the timeout clock
    int tq[$]; // Cycle of each pin change
    logic lq[$]; // Pin level after each change
    logic last_pin = 1'b0;
    logic [31:0] seed = 32'h00010D00; // Random state, fixed start

    always #4 sys_clk = ~sys_clk;

    pwt_top pwt_top_inst (
        .sys_clk_i(sys_clk),
        .rst_i(rst),
        .apb_i(req),
        .apb_o(rsp),
        .companion_uflow_i(comp_pulse),
        .waveform_out_pin_o(pin),
        .irq_o(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Ends the run; the single exit point of the bench
    task test_done;
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One comparison, counted and reported
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Galois shift register, fixed polynomial; shifts right so the seed bits reach the fields at once
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'hEDB88320 : 32'h00000000);
    endfunction

    // One APB transfer; request held until pready is sampled high
    task apb(input logic is_wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rv, output logic ev);
        int k;
        k = 0;
        @(posedge sys_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= is_wr;
        req.paddr <= a;
        req.pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (rsp.pready !== 1'b1 && k < 50);
        // Read data and error are taken at the completing edge only
        rv = rsp.prdata[7:0];
        ev = rsp.pslverr;
        if (k >= 50)
            chk(32'h0, 32'h1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] rv;
        logic ev;
        apb(1'b1, a, d, rv, ev);
    endtask

    task rd(input logic [7:0] a, output logic [7:0] rv);
        logic ev;
        apb(1'b0, a, 8'h00, rv, ev);
    endtask

    // Waits for a number of pin changes, bounded so a stuck pin cannot hang
    task wait_tog(input int nq);
        int k;
        k = 0;
        while (tq.size() < nq && k < 5000)
        begin
            @(posedge sys_clk);
            k++;
        end
        chk(32'(tq.size() >= nq), 32'h1);
    endtask

    // Reference model: interval length from the level it was held at
    task chk_iv(input int from, input int n, input int m, input int p, input int sc, input logic opl);
        int e;
        for (int i = from; i < tq.size(); i++)
        begin
            e = (lq[i - 1] == opl) ? (n + 1) * (m + 1) * sc : (n + 1) * (p + 1) * sc;
            chk(32'(tq[i] - tq[i - 1]), 32'(e));
        end
    endtask

    // Stopped setup of all reload values, then start in waveform mode
    task start(input logic [1:0] sel, input int n, input int m, input int p, input logic opl);
        logic [7:0] v;
        wr(ADDR_MODE, 8'h50);
        wr(ADDR_PRESC, 8'(n));
        wr(ADDR_SEC, 8'(p));
        wr(ADDR_PRI, 8'(m));
        rd(ADDR_PRI, v);
        chk(32'(v), 32'(m));
        rd(ADDR_PRESC, v);
        chk(32'(v), 32'(n));
        wr(ADDR_CTL, {6'h00, sel});
        wr(ADDR_WOC, {2'h0, opl, 5'h00});
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_OCR, 8'h00);
        wr(ADDR_MODE, 8'hD0); // Run, write target, waveform mode
        // Start is seen one edge after the write, the pin one edge later
        repeat (2) @(posedge sys_clk);
        chk(32'(pin), 32'(opl));
        // One more edge so the start level change is not logged as an interval
        @(posedge sys_clk);
        tq.delete();
        lq.delete();
    endtask

    // ------------------------------------------------------------
    // Stimulus helpers, timeout and pin monitor
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        comp_div <= (comp_div == 2'h2) ? 2'h0 : comp_div + 2'h1;
        comp_pulse <= (comp_div == 2'h2);
        cyc <= cyc + 1;
        // Pre-edge values are seen here, so change times are exact
        if (pin !== last_pin)
        begin
            tq.push_back(cyc);
            lq.push_back(pin);
            last_pin = pin;
        end
        if (cyc == 40000)
        begin
            error_cnt++;
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n, m, p, m2, p2;
        int sc[4];
        logic opl;
        logic [7:0] v;
        logic ev;
        sc = '{1, 2, 8, 3}; // Tick spacing per clock select
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADDR_MODE, v);
        chk(32'(v), 32'h00); // Reset value of the mode register
        rd(ADDR_WOC, v);
        chk(32'(v), 32'h00); // Reset value of the output control
        rd(ADDR_PRI, v);
        chk(32'(v), 32'hFF);
        apb(1'b0, 8'hA4, 8'h00, v, ev);
        chk(32'({ev, v}), 32'h100); // Unmapped address refused
        for (int s = 0; s < 4; s++)
        begin
            seed = lfsr_next(seed);
            n = seed[9];
            m = 8 + seed[12:10];
            p = 8 + seed[6:4];
            opl = seed[7];
            m2 = 8 + seed[10:8];
            p2 = 8 + seed[13:11];
            start(2'(s), n, m, p, opl);
            wait_tog(4);
            chk_iv(1, n, m, p, sc[s], opl);
            chk(32'(irq), 32'h1);
            // Running writes: secondary first, primary commits both
            wr(ADDR_SEC, 8'(p2));
            wr(ADDR_PRI, 8'(m2));
            tq.delete();
            lq.delete();
            wait_tog(7);
            chk_iv(4, n, m2, p2, sc[s], opl);
            wr(ADDR_MODE, 8'h50);
            repeat (2) @(posedge sys_clk);
            chk(32'(pin), 32'h0);
            rd(ADDR_STAT, v);
            chk(32'(v[ST_CYCLE]), 32'h1);
            rd(ADDR_STAT, v);
            chk(32'(v), 32'h00); // Status cleared by the read
            repeat (2) @(posedge sys_clk);
            chk(32'(irq), 32'h0);
        end
        // Output switch taken at an interrupt; pin then drives the latch
        start(SEL_DIV_ONE, 0, 8, 8, 1'b0);
        wr(ADDR_CTL, 8'h04);
        wr(ADDR_MASK, 8'h00);
        wr(ADDR_OCR, 8'h01);
        repeat (60) @(posedge sys_clk);
        tq.delete();
        repeat (60) @(posedge sys_clk);
        chk(32'(tq.size()), 32'h0);
        chk(32'(pin), 32'h1);
        chk(32'(irq), 32'h0); // Masked events raise nothing
        test_done;
    end

endmodule

`default_nettype wire
